/* src/wim_filter.sv */
// glitch filter with edge detect for one wake input
`timescale 1ns/1ns
module wim_filter #(
   parameter int CNT_W = 10
) (
   input wire logic clk_i,               // system clock
   input wire logic rst_i,               // sync reset, high
   input wire logic in_i,                // comparator output
   input wire logic active_i,            // evaluation window open
   input wire logic [CNT_W-1:0] limit_i, // filter length in cycles
   output logic level_o,                 // filtered level
   output logic edge_o                   // accepted edge, one cycle
);
   typedef struct packed {
      logic init;
      logic last;
      logic stable;
      logic [CNT_W-1:0] cnt;
      logic edge_p;
   } wim_flt_st_t;

   wim_flt_st_t s_r, s_nxt;

   // first cycle after reset adopts the pin level so no false edge
   always_comb begin
      s_nxt = s_r;
      s_nxt.edge_p = 1'b0;
      s_nxt.last = in_i;
      s_nxt.init = 1'b1;
      if (!s_r.init) begin
         s_nxt.stable = in_i;
         s_nxt.cnt = '0;
      end else if (!active_i) begin
         s_nxt.cnt = '0;
      end else if (in_i != s_r.last) begin
         s_nxt.cnt = '0;
      end else if (in_i != s_r.stable) begin
         if (s_r.cnt >= limit_i - 1'b1) begin
            s_nxt.stable = in_i;
            s_nxt.edge_p = 1'b1;
            s_nxt.cnt = '0;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end else begin
         s_nxt.cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level_o = s_r.stable;
   assign edge_o = s_r.edge_p;

   a_edge_moves_level: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_o |-> level_o != $past(level_o))
      else $error("edge without level change");
   a_crossing_restarts: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.init && in_i != s_r.last) |=> !edge_o [*8])
      else $error("edge too soon after crossing");
   a_idle_no_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      !active_i |=> !edge_o)
      else $error("edge outside window");
endmodule

/* src/wim_pkg.sv */
// constants and types shared by the wake input monitor
// How it works
// - both edge directions of a pin signal wake
// - interrupt in normal/stop, wake in sleep/failsafe
// - static sense evaluates inputs all the time
// - filter 00 static 16us, 01 static 64us
// - filter 10/11 cyclic on timer one/two, 16us
// - cyclic sense evaluates only inside timer window
// - edge accepted only if stable whole filter time
// - per pin software enable as wake source
// - per pin wake source flags always readable
// - level status shown in normal and stop
// - cyclic sense level status holds window samples
// - failsafe pins use 16us, second status register
// - pull field 00 none, 01 down, 10 up, 11 auto
// - auto pull follows pin level
// - measure mode gates first two pins in normal
package wim_pkg;
   // clock rate and filter times
   localparam int CLK_MHZ = 10;
   localparam int FLT_SHORT_US = 16;
   localparam int FLT_LONG_US = 64;
   localparam int FLT_SHORT_CYC = FLT_SHORT_US * CLK_MHZ;
   localparam int FLT_LONG_CYC = FLT_LONG_US * CLK_MHZ;
   localparam int CNT_W = 10;
   // register byte offsets
   localparam logic [7:0] ADR_PIN_EN = 8'h00;
   localparam logic [7:0] ADR_PULL = 8'h04;
   localparam logic [7:0] ADR_FLT = 8'h08;
   localparam logic [7:0] ADR_MEAS = 8'h0c;
   localparam logic [7:0] ADR_SRC = 8'h10;
   localparam logic [7:0] ADR_ALT = 8'h14;
   localparam logic [7:0] ADR_LVL = 8'h18;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ADR_IRQ_CLR = 8'h20;
   localparam logic [7:0] ADR_IRQ_EN = 8'h24;
   // field positions: failsafe pins sit at bit 8 in enable and irq layouts
   localparam int ALT_POS = 8;
   localparam int MEAS_POS = 0;
   // reset values
   localparam logic [15:0] PULL_RST = 16'h0000;
   localparam logic [15:0] FLT_RST = 16'h0000;
   localparam logic [9:0] EN_RST = 10'h000;
   // device operating mode, gray along normal-stop-sleep-failsafe
   typedef enum logic [1:0] {
      WIM_NORMAL = 2'b00,
      WIM_STOP = 2'b01,
      WIM_SLEEP = 2'b11,
      WIM_FAILSAFE = 2'b10
   } wim_mode_t;
   typedef enum logic [1:0] {
      WIM_FLT_A = 2'b00,
      WIM_FLT_B = 2'b01,
      WIM_FLT_C = 2'b10,
      WIM_FLT_D = 2'b11
   } wim_flt_t;
   typedef enum logic [1:0] {
      WIM_PULL_NONE = 2'b00,
      WIM_PULL_DOWN = 2'b01,
      WIM_PULL_UP = 2'b10,
      WIM_PULL_AUTO = 2'b11
   } wim_pull_t;
endpackage

/* src/wim_top.sv */
// wake input monitor with wishbone register slave
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module wim_top #(
   parameter int NUM_WAKE = 3
) (
   input wire logic clk_i,                            // 10 MHz clock
   input wire logic rst_i,                            // sync reset, high
   input wire logic wb_cyc_i,                         // bus cycle
   input wire logic wb_stb_i,                         // bus strobe
   input wire logic wb_we_i,                          // write enable
   input wire logic [7:0] wb_adr_i,                   // byte address
   input wire logic [3:0] wb_sel_i,                   // byte lanes
   input wire logic [31:0] wb_dat_i,                  // write data
   output logic [31:0] wb_dat_o,                      // read data
   output logic wb_ack_o,                             // bus ack
   input wire wim_pkg::wim_mode_t sbc_mode_i,         // device mode
   input wire logic [NUM_WAKE-1:0] wake_pin_i,        // pin comparators
   input wire logic [1:0] failsafe_output_pins_i,     // alt wake inputs
   input wire logic timer_one_win_i,                  // timer one on-time
   input wire logic timer_two_win_i,                  // timer two on-time
   output logic irq_o,                                // interrupt level
   output logic wake_o,                               // wake pulse
   output logic [NUM_WAKE-1:0] pull_up_en_o,          // pull-up sources
   output logic [NUM_WAKE-1:0] pull_dn_en_o           // pull-down sources
);
   import wim_pkg::*;

   localparam int NW = NUM_WAKE;
   localparam int NF = NW + 2;
   localparam logic [CNT_W-1:0] LIM_S = CNT_W'(FLT_SHORT_CYC);
   localparam logic [CNT_W-1:0] LIM_L = CNT_W'(FLT_LONG_CYC);

   // irq layout holds pins in the low byte, so at most eight pins
   if (NUM_WAKE < 2 || NUM_WAKE > 8) begin : g_chk_pins
      $error("NUM_WAKE must be 2 to 8");
   end
   if (FLT_LONG_CYC >= (1 << CNT_W)) begin : g_chk_cnt
      $error("filter counter too narrow");
   end
   // failsafe enable bits must sit above the pin bits and inside the word
   if (ALT_POS < NUM_WAKE || ALT_POS > 30) begin : g_chk_alt
      $error("failsafe field overlaps pin field");
   end
   // the filter compares against limit minus one, so the short limit needs two cycles
   if (FLT_SHORT_CYC < 2) begin : g_chk_lim
      $error("filter limit too short");
   end

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [NW-1:0] pin_en;
      logic [1:0] fso_en;
      logic [2*NW-1:0] pull;
      logic [2*NW-1:0] flt;
      logic meas;
      logic [NW-1:0] src;
      logic [1:0] alt;
      logic [NW-1:0] lvl;
      logic [NW-1:0] irq_en;
      logic [1:0] alt_irq_en;
      logic irq;
      logic wake;
      logic [NW-1:0] pu;
      logic [NW-1:0] pd;
   } wim_st_t;

   wim_st_t s_r, s_nxt;

   logic [NF-1:0] f_in;
   logic [NF-1:0] f_act;
   logic [NF-1:0] f_lvl;
   logic [NF-1:0] f_edge;
   logic [CNT_W-1:0] f_lim [NF];
   logic [NW-1:0] gate;
   logic [NW-1:0] cyc_win;
   logic [NW-1:0] is_cyc;
   logic active_mode;
   logic low_power;

   // pull decode: returns {up, down} from field and filtered level
   function automatic logic [1:0] pull_dec(input logic [1:0] fld, input logic lvl);
      logic [1:0] r;
      r = 2'b00;
      unique case (wim_pull_t'(fld))
         WIM_PULL_NONE: r = 2'b00;
         WIM_PULL_DOWN: r = 2'b01;
         WIM_PULL_UP: r = 2'b10;
         WIM_PULL_AUTO: r = lvl ? 2'b10 : 2'b01;
      endcase
      return r;
   endfunction

   // evaluation window: shut while gated, else static pins always, cyclic pins only inside their timer window
   function automatic logic win_open(input logic gated, input logic cyc, input logic win);
      return !gated && (!cyc || win);
   endfunction

   // filter selection per pin; measure mode blinds the first two pins in normal mode
   assign active_mode = (sbc_mode_i == WIM_NORMAL) || (sbc_mode_i == WIM_STOP);
   assign low_power = !active_mode;
   always_comb begin
      for (int i = 0; i < NW; i++) begin
         gate[i] = s_r.meas && (sbc_mode_i == WIM_NORMAL) && (i < 2);
         is_cyc[i] = s_r.flt[2*i+1];
         cyc_win[i] = s_r.flt[2*i] ? timer_two_win_i : timer_one_win_i;
         f_in[i] = wake_pin_i[i];
         f_act[i] = win_open(gate[i], is_cyc[i], cyc_win[i]);
         f_lim[i] = (wim_flt_t'(s_r.flt[2*i +: 2]) == WIM_FLT_B) ? LIM_L : LIM_S;
      end
      for (int j = 0; j < 2; j++) begin
         f_in[NW+j] = failsafe_output_pins_i[j];
         f_act[NW+j] = 1'b1;
         f_lim[NW+j] = LIM_S;
      end
   end

   // one filter per wake input and per failsafe pin
   for (genvar k = 0; k < NF; k++) begin : g_flt
      wim_filter #(
         .CNT_W(CNT_W)
      ) u_flt (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .in_i(f_in[k]),
         .active_i(f_act[k]),
         .limit_i(f_lim[k]),
         .level_o(f_lvl[k]),
         .edge_o(f_edge[k])
      );
   end

   // next state: bus, status, level, pulls and outputs
   always_comb begin
      logic [NW-1:0] ev;
      logic [1:0] aev;
      logic [NW-1:0] clr;
      logic [1:0] aclr;
      logic wr;
      logic rd;
      logic [1:0] pd;
      ev = '0;
      aev = '0;
      clr = '0;
      aclr = '0;
      pd = '0;
      s_nxt = s_r;
      // a write lands on the taking edge, the same edge that raises ack to the master
      wr = wb_cyc_i && wb_stb_i && !s_r.ack && wb_we_i && wb_sel_i[0];
      rd = wb_cyc_i && wb_stb_i && !s_r.ack && !wb_we_i;
      // single wait state; ack drops the cycle after it is given
      s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
      // a gated pin keeps its old filtered level; leaving measure mode with the pin moved
      // reports that move as a fresh edge one filter time later
      // events: enabled, not gated, filtered edges
      ev = f_edge[NW-1:0] & s_r.pin_en & ~gate;
      aev = f_edge[NW+1:NW] & s_r.fso_en;
      // register writes; only low-byte and second-byte lanes hold fields
      if (wr) begin
         unique case (wb_adr_i)
            ADR_PIN_EN: begin
               s_nxt.pin_en = wb_dat_i[NW-1:0];
               if (wb_sel_i[1]) begin
                  s_nxt.fso_en = wb_dat_i[ALT_POS +: 2];
               end
            end
            ADR_PULL: begin
               s_nxt.pull = wb_dat_i[2*NW-1:0];
            end
            ADR_FLT: begin
               s_nxt.flt = wb_dat_i[2*NW-1:0];
            end
            ADR_MEAS: begin
               s_nxt.meas = wb_dat_i[MEAS_POS];
            end
            ADR_IRQ_CLR: begin
               clr = wb_dat_i[NW-1:0];
               if (wb_sel_i[1]) begin
                  aclr = wb_dat_i[ALT_POS +: 2];
               end
            end
            ADR_IRQ_EN: begin
               s_nxt.irq_en = wb_dat_i[NW-1:0];
               if (wb_sel_i[1]) begin
                  s_nxt.alt_irq_en = wb_dat_i[ALT_POS +: 2];
               end
            end
            default: begin
            end
         endcase
      end
      // sticky flags: a new event beats a clear in the same cycle
      s_nxt.src = (s_r.src & ~clr) | ev;
      s_nxt.alt = (s_r.alt & ~aclr) | aev;
      // level status: live in static sense, window samples in cyclic
      for (int i = 0; i < NW; i++) begin
         if (active_mode && win_open(gate[i], is_cyc[i], cyc_win[i])) begin
            s_nxt.lvl[i] = wake_pin_i[i];
         end
      end
      // pulls are forced off for measure-gated pins
      for (int i = 0; i < NW; i++) begin
         pd = gate[i] ? 2'b00 : pull_dec(s_r.pull[2*i +: 2], f_lvl[i]);
         s_nxt.pu[i] = pd[1];
         s_nxt.pd[i] = pd[0];
      end
      // interrupt only in active modes, wake only in low-power modes
      s_nxt.irq = active_mode && (|(s_nxt.src & s_nxt.irq_en) || |(s_nxt.alt & s_nxt.alt_irq_en));
      s_nxt.wake = low_power && (|ev || |aev);
      // read data; unmapped and write-only addresses read zero
      s_nxt.rdat = '0;
      if (rd) begin
         unique case (wb_adr_i)
            ADR_PIN_EN: begin
               s_nxt.rdat[NW-1:0] = s_r.pin_en;
               s_nxt.rdat[ALT_POS +: 2] = s_r.fso_en;
            end
            ADR_PULL: s_nxt.rdat[2*NW-1:0] = s_r.pull;
            ADR_FLT: s_nxt.rdat[2*NW-1:0] = s_r.flt;
            ADR_MEAS: s_nxt.rdat[MEAS_POS] = s_r.meas;
            ADR_SRC: s_nxt.rdat[NW-1:0] = s_r.src;
            ADR_ALT: s_nxt.rdat[1:0] = s_r.alt;
            ADR_LVL: s_nxt.rdat[NW-1:0] = s_r.lvl;
            ADR_IRQ_STAT: begin
               s_nxt.rdat[NW-1:0] = s_r.src;
               s_nxt.rdat[ALT_POS +: 2] = s_r.alt;
            end
            ADR_IRQ_EN: begin
               s_nxt.rdat[NW-1:0] = s_r.irq_en;
               s_nxt.rdat[ALT_POS +: 2] = s_r.alt_irq_en;
            end
            default: s_nxt.rdat = '0;
         endcase
      end
   end

   // reset: pulls off, static 16us filters, every source disabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.pull <= PULL_RST[2*NW-1:0];
         s_r.flt <= FLT_RST[2*NW-1:0];
         s_r.pin_en <= EN_RST[NW-1:0];
      end else begin
         s_r <= s_nxt;
      end
   end

   // every output is a flop of the state record, no logic after it
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign irq_o = s_r.irq;
   assign wake_o = s_r.wake;
   assign pull_up_en_o = s_r.pu;
   assign pull_dn_en_o = s_r.pd;

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_wake_low_power: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_o |-> $past(low_power) && $past(|f_edge))
      else $error("wake pulse in active mode");
   a_irq_active_only: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o |-> $past(active_mode) && (|s_r.src || |s_r.alt))
      else $error("interrupt without cause or mode");
   a_edge_sets_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (f_edge[0] && s_r.pin_en[0] && !gate[0]) |=> s_r.src[0])
      else $error("event lost, set must beat clear");
   a_meas_gates_lvl: assert property (@(posedge clk_i) disable iff (rst_i)
      gate[0] |=> s_r.lvl[0] == $past(s_r.lvl[0]) && !s_r.pu[0] && !s_r.pd[0])
      else $error("gated pin updated");
   a_pull_auto: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.pull[1:0] == 2'b11 && !gate[0]) |=> s_r.pu[0] == $past(f_lvl[0]) && s_r.pd[0] != s_r.pu[0])
      else $error("auto pull not following level");

   // bus: ack only answers a request, read data is zero between answers
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");

   // mode split of interrupt and wake
   a_wake_active_none: assert property (@(posedge clk_i) disable iff (rst_i)
      active_mode |=> !wake_o)
      else $error("wake pulse from active mode");
   a_irq_low_power: assert property (@(posedge clk_i) disable iff (rst_i)
      low_power |=> !irq_o)
      else $error("interrupt in low-power mode");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == ($past(active_mode) && (|(s_r.src & s_r.irq_en) || |(s_r.alt & s_r.alt_irq_en))))
      else $error("interrupt not following enabled flags");

   // sticky flags move only on events and clear writes
   a_src_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(s_r.src[0]) |-> $past(wb_we_i && wb_adr_i == ADR_IRQ_CLR && wb_dat_i[0]))
      else $error("wake source flag lost");
   a_clr_clears_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_IRQ_CLR && wb_dat_i[0]
         && !f_edge[0]) |=> !s_r.src[0])
      else $error("clear write ignored");
   a_src_needs_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s_r.src[0]) |-> $past(f_edge[0] && s_r.pin_en[0]))
      else $error("wake source flag without enabled edge");
   a_gate_no_src: assert property (@(posedge clk_i) disable iff (rst_i)
      gate[1] |=> !$rose(s_r.src[1]))
      else $error("gated pin raised a flag");
   a_alt_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      (f_edge[NW] && s_r.fso_en[0]) |=> s_r.alt[0])
      else $error("failsafe pin event lost");
   a_alt_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(s_r.alt[0]) |-> $past(wb_we_i && wb_adr_i == ADR_IRQ_CLR && wb_sel_i[1] && wb_dat_i[ALT_POS]))
      else $error("failsafe flag lost");

   // level status: live in static sense, window samples in cyclic, frozen in low power
   a_lvl_static_live: assert property (@(posedge clk_i) disable iff (rst_i)
      (active_mode && !gate[0] && !is_cyc[0]) |=> s_r.lvl[0] == $past(wake_pin_i[0]))
      else $error("level status not live");
   a_lvl_cyc_open: assert property (@(posedge clk_i) disable iff (rst_i)
      (active_mode && !gate[NW-1] && is_cyc[NW-1] && cyc_win[NW-1]) |=> s_r.lvl[NW-1] == $past(wake_pin_i[NW-1]))
      else $error("window sample missed");
   a_lvl_cyc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_cyc[NW-1] && !cyc_win[NW-1]) |=> s_r.lvl[NW-1] == $past(s_r.lvl[NW-1]))
      else $error("level changed outside window");
   a_lvl_low_power: assert property (@(posedge clk_i) disable iff (rst_i)
      low_power |=> s_r.lvl == $past(s_r.lvl))
      else $error("level status moved in low power");

   // pull sources: fixed settings, never both at once, off while measuring
   a_pull_none: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.pull[1:0] == 2'b00) |=> !pull_up_en_o[0] && !pull_dn_en_o[0])
      else $error("pull source with field none");
   a_pull_up_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.pull[1:0] == 2'b10 && !gate[0]) |=> pull_up_en_o[0] && !pull_dn_en_o[0])
      else $error("pull-up setting not applied");
   a_pull_dn_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.pull[3:2] == 2'b01 && !gate[1]) |=> !pull_up_en_o[1] && pull_dn_en_o[1])
      else $error("pull-down setting not applied");
   a_pull_not_both: assert property (@(posedge clk_i) disable iff (rst_i)
      (pull_up_en_o & pull_dn_en_o) == '0)
      else $error("pull-up and pull-down both on");
   a_gate_no_pull: assert property (@(posedge clk_i) disable iff (rst_i)
      gate[1] |=> !pull_up_en_o[1] && !pull_dn_en_o[1])
      else $error("gated pin kept a pull source");
endmodule

/* tb/tb_wim_top.sv */
// self-checking bench for the wake input monitor
`timescale 1ns/1ns
module tb_wim_top;
   import wim_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o, wake_o, t_one, t_two;
   wim_mode_t sbc_mode_i = WIM_NORMAL;
   logic [2:0] wake_pin_i, pull_up_en_o, pull_dn_en_o;
   logic [1:0] fs_pins;
   int num_errors = 0;
   int tests_run = 0;
   int wake_cnt = 0;
   wim_mode_t mt [4] = '{WIM_NORMAL, WIM_STOP, WIM_SLEEP, WIM_FAILSAFE};
   always #50 clk_i = ~clk_i;
   // count wake pulses so a missing or doubled pulse shows up
   always @(posedge clk_i) if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
   wim_top #(.NUM_WAKE(3)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .sbc_mode_i(sbc_mode_i), .wake_pin_i(wake_pin_i), .failsafe_output_pins_i(fs_pins),
      .timer_one_win_i(t_one), .timer_two_win_i(t_two), .irq_o(irq_o), .wake_o(wake_o),
      .pull_up_en_o(pull_up_en_o), .pull_dn_en_o(pull_dn_en_o));
   wim_pins pins_u (.clk_i(clk_i), .wake_pin_o(wake_pin_i), .fs_pin_o(fs_pins), .win_one_o(t_one),
      .win_two_o(t_two));
   // expected {up, dn} enables for a pull field and the pin levels
   function automatic logic [5:0] exp_pull(input logic [5:0] f, input logic [2:0] lv);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < 3; i++) begin
         r[3+i] = f[2*i+1] & (~f[2*i] | lv[i]);
         r[i] = f[2*i] & (~f[2*i+1] | ~lv[i]);
      end
      return r;
   endfunction
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle; the request stands until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wb(1'b1, adr, dat, q);
   endtask
   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, adr, 32'h0, q);
      chk(q, exp);
   endtask
   // a random bounce shorter than the filter is ignored, a clean flip is taken
   task automatic ev(input int i, input int lim, input logic [31:0] exp_src);
      pins_u.flip(i, $urandom_range(lim - 3, lim / 2));
      pins_u.flip(i, lim + 8);
      rdchk(ADR_IRQ_STAT, 32'h0);
      pins_u.flip(i, lim + 8);
      rdchk(ADR_IRQ_STAT, exp_src);
   endtask
   initial begin
      logic [31:0] lv;
      int w0;
      logic act;
      void'($urandom(11412));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(ADR_PIN_EN, 32'h0);
      rdchk(ADR_PULL, 32'h0);
      rdchk(ADR_FLT, 32'h0);
      rdchk(8'h30, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      // one pin each of up, down and automatic
      wr(ADR_PULL, 32'h36);
      rdchk(ADR_PULL, 32'h36);
      chk({26'h0, pull_up_en_o, pull_dn_en_o}, {26'h0, exp_pull(6'h36, 3'h0)});
      wr(ADR_PIN_EN, 32'h107);
      wr(ADR_IRQ_EN, 32'h307);
      wr(ADR_FLT, 32'h24);
      ev(0, FLT_SHORT_CYC, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      wr(ADR_IRQ_CLR, 32'h3ff);
      ev(1, FLT_LONG_CYC, 32'h2);
      rdchk(ADR_LVL, {29'h0, pins_u.p[2:0]});
      wr(ADR_IRQ_CLR, 32'h3ff);
      // cyclic sense sees nothing while its window stays shut
      lv = {29'h0, pins_u.p[2:0]};
      pins_u.flip(2, 400);
      rdchk(ADR_SRC, 32'h0);
      rdchk(ADR_LVL, lv);
      @(posedge clk_i);
      pins_u.en <= 2'h1;
      repeat (700) @(posedge clk_i);
      rdchk(ADR_SRC, 32'h4);
      rdchk(ADR_LVL, {29'h0, pins_u.p[2:0]});
      chk({26'h0, pull_up_en_o, pull_dn_en_o}, {26'h0, exp_pull(6'h36, pins_u.p[2:0])});
      wr(ADR_IRQ_CLR, 32'h3ff);
      // config d listens to timer two only
      wr(ADR_FLT, 32'h34);
      pins_u.flip(2, 700);
      rdchk(ADR_SRC, 32'h0);
      @(posedge clk_i);
      pins_u.en <= 2'h2;
      repeat (700) @(posedge clk_i);
      rdchk(ADR_SRC, 32'h4);
      wr(ADR_IRQ_CLR, 32'h3ff);
      // interrupt in the active modes, wake pulse in the low-power ones
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_i);
         sbc_mode_i <= mt[m];
         w0 = wake_cnt;
         pins_u.flip(0, 170);
         act = (m < 2);
         chk({31'h0, irq_o}, {31'h0, act});
         chk(wake_cnt - w0, {31'h0, ~act});
         @(posedge clk_i);
         sbc_mode_i <= WIM_NORMAL;
         rdchk(ADR_SRC, 32'h1);
         wr(ADR_IRQ_CLR, 32'h3ff);
      end
      wr(ADR_PIN_EN, 32'h106);
      pins_u.flip(0, 200);
      rdchk(ADR_SRC, 32'h0);
      rdchk(ADR_LVL, {29'h0, pins_u.p[2:0]});
      wr(ADR_PIN_EN, 32'h107);
      wr(ADR_MEAS, 32'h1);
      lv = {29'h0, pins_u.p[2:0]};
      pins_u.flip(0, 200);
      pins_u.flip(1, 200);
      rdchk(ADR_SRC, 32'h0);
      rdchk(ADR_LVL, lv);
      wr(ADR_MEAS, 32'h0);
      // failsafe pin event, first masked then unmasked
      wr(ADR_IRQ_EN, 32'h0);
      pins_u.flip(3, 170);
      rdchk(ADR_ALT, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      wr(ADR_IRQ_EN, 32'h100);
      rdchk(ADR_IRQ_EN, 32'h100);
      chk({31'h0, irq_o}, 32'h1);
      wr(ADR_IRQ_CLR, 32'h100);
      rdchk(ADR_ALT, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      wrap_up();
   end
endmodule

/* tb/wim_pins.sv */
// behavioural switches and timer windows on the far side of the wake inputs
`timescale 1ns/1ns
module wim_pins (
   input wire logic clk_i,         // system clock
   output logic [2:0] wake_pin_o,  // switch levels at the wake pins
   output logic [1:0] fs_pin_o,    // failsafe pins used as wake inputs
   output logic win_one_o,         // timer one on-time
   output logic win_two_o          // timer two on-time
);
   logic [4:0] p = 5'h00;
   logic [1:0] en = 2'h0;
   int cnt = 0;
   assign wake_pin_o = p[2:0];
   assign fs_pin_o = p[4:3];
   // 300 of 500 cycles open, long enough for one 16us filter run to finish
   assign win_one_o = en[0] && cnt < 300;
   assign win_two_o = en[1] && cnt < 300;
   always @(posedge clk_i) cnt <= (cnt == 499) ? 0 : cnt + 1;
   // a switch flips and stays put for n cycles; a short n models a bounce
   task automatic flip(input int i, input int n);
      @(posedge clk_i);
      p[i] <= ~p[i];
      repeat (n) @(posedge clk_i);
   endtask
endmodule
